/* File: pkg/ipc_pkg.sv */
// package of constants and types for the injector command and fault block
// assumes a single 100 MHz clock domain
package ipc_pkg;
  localparam int          CLK_MHZ        = 100;
  localparam int          NCH            = 4;
  localparam int          TIME_W         = 16;
  localparam int          CNT_W          = 32;
  localparam int          US_PER_MS      = 1000;
  // cycles in one millisecond, derived from the clock rate
  localparam int          CYC_PER_MS     = US_PER_MS * CLK_MHZ;
  localparam logic [3:0]  CH_RST         = 4'h0;
  localparam logic [CNT_W-1:0] CNT_RST   = 32'h0000_0000;

  typedef enum logic [3:0] {
    IPC_DIRECT = 4'h1,
    IPC_CAL    = 4'h2,
    IPC_TRIG   = 4'h4,
    IPC_ANGLE  = 4'h8
  } ipc_mode_t;

  typedef enum logic [2:0] {
    IPC_TP_OFF = 3'h0,
    IPC_TP_CH1 = 3'h1,
    IPC_TP_CH2 = 3'h2,
    IPC_TP_CH3 = 3'h3,
    IPC_TP_CH4 = 3'h4
  } ipc_tpsel_t;

  typedef enum logic [2:0] {
    IPC_S_IDLE = 3'h1,
    IPC_S_ON   = 3'h2,
    IPC_S_OFF  = 3'h4
  } ipc_seq_t;

  // count of channels enabled in a mask
  function automatic logic [2:0] ipc_popcount(input logic [3:0] m);
    ipc_popcount = {2'h0, m[0]} + {2'h0, m[1]} + {2'h0, m[2]} + {2'h0, m[3]};
  endfunction
endpackage

/* File: pkg/ipc_chan_if.sv */
// interface carrying per-channel command and current status to fault logic
// assumes both ends share CLK
`timescale 1ns/10ps
interface ipc_chan_if;
  logic [3:0] cmd;
  logic [3:0] cmd_end;
  logic [3:0] ls_end;
  logic [7:0] short_det;
  logic [7:0] low_reached;
  logic [7:0] clear;
  logic       override;
  logic [7:0] short_flag;
  logic [7:0] open_flag;
  modport ctl (output cmd, cmd_end, ls_end, short_det, low_reached, clear,
               override, input short_flag, open_flag);
  modport flt (input cmd, cmd_end, ls_end, short_det, low_reached, clear,
               override, output short_flag, open_flag);
endinterface

/* File: rtl/ipc_fault.sv */
// fault flag store: short flags latch, open flags update at pulse end and clear in any cycle with override
// assumes channel bits 3:0 injector, 7:4 lowside
`timescale 1ns/10ps
module ipc_fault (
  input wire logic CLK,
  input wire logic RST_N,
  ipc_chan_if.flt  ch
);
  import ipc_pkg::*;
  logic [7:0] short_r, short_nxt;
  logic [7:0] open_r, open_nxt;
  logic [7:0] seen_r, seen_nxt;
  logic [7:0] ends;

  always_comb begin
    // lowside pulses are timed outside, so their ends arrive as strobes
    ends = {ch.ls_end, ch.cmd_end};
    // detection wins over a clear arriving in the same cycle
    short_nxt = (short_r & ~ch.clear) | ch.short_det;
    seen_nxt = seen_r | ch.low_reached;
    open_nxt = open_r;
    for (int i = 0; i < 8; i++) begin
      if (ends[i]) begin
        open_nxt[i] = ~ch.override & ~(seen_r[i] | ch.low_reached[i]);
        seen_nxt[i] = 1'b0;
      end
    end
    if (ch.override) begin
      open_nxt = 8'h00;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      short_r <= 8'h00;
      open_r  <= 8'h00;
      seen_r  <= 8'h00;
    end else begin
      short_r <= short_nxt;
      open_r  <= open_nxt;
      seen_r  <= seen_nxt;
    end
  end

  assign ch.short_flag = short_r;
  assign ch.open_flag  = open_r;

  property p_short_hold;
    @(posedge CLK) disable iff (!RST_N)
      short_r[0] && !ch.clear[0] |=> short_r[0];
  endproperty
  a_short_hold: assert property (p_short_hold) else $error("short lost");

  property p_override;
    @(posedge CLK) disable iff (!RST_N)
      ch.override |=> open_r == 8'h00;
  endproperty
  a_override: assert property (p_override) else $error("open shown");

  property p_open_set;
    @(posedge CLK) disable iff (!RST_N)
      ch.cmd_end[1] && !ch.override && !seen_r[1] && !ch.low_reached[1]
      |=> open_r[1];
  endproperty
  a_open_set: assert property (p_open_set) else $error("open missed");

  c_short: cover property (@(posedge CLK) short_r[2]);
  c_open:  cover property (@(posedge CLK) open_r[0]);
endmodule

/* File: rtl/ipc_top.sv */
// injector command mode selection, test pulse and fault reporting
// assumes synchronous inputs; sequence timing arrives as configuration
`timescale 1ns/10ps
module ipc_top (
  // clock and reset
  input  wire logic                   CLK,
  input  wire logic                   RST_N,
  // module control
  input  wire logic                   MODULE_ENABLE,
  input  wire logic                   SLOT_OCCUPIED,
  input  wire logic                   EXT_POWERED,
  input  wire ipc_pkg::ipc_mode_t     COMMAND_MODE_SELECT,
  input  wire logic [3:0]             CHAN_ENABLE,
  // direct and trigger inputs
  input  wire logic [3:0]             DIG_IN,
  input  wire logic [3:0]             DIG_INVERT,
  input  wire logic                   TRIG_FALLING,
  input  wire logic                   ANGLE_EVENT,
  // sequence and calibration timing in cycles, and pulse count
  input  wire logic [ipc_pkg::CNT_W-1:0] PULSE_ON_CYC,
  input  wire logic [ipc_pkg::CNT_W-1:0] PULSE_PERIOD_CYC,
  input  wire logic [ipc_pkg::TIME_W-1:0] PULSE_COUNT,
  // test pulse
  input  wire logic                   TEST_PULSE_REQUEST,
  input  wire ipc_pkg::ipc_tpsel_t    TEST_PULSE_CHANNEL,
  input  wire logic [ipc_pkg::TIME_W-1:0] TEST_PULSE_DURATION,
  // faults and current sense
  input  wire logic                   CRITICAL_FAULT_CLEAR,
  input  wire logic                   OPEN_FAULT_OVERRIDE,
  input  wire logic [7:0]             SHORT_DETECT,
  input  wire logic [7:0]             LOW_SETPOINT_REACHED,
  input  wire logic [3:0]             LOWSIDE_CMD_END,
  // outputs
  output logic                        MODULE_PRESENT_FLAG,
  output logic [3:0]                  INJ_CMD,
  output logic [3:0]                  LOWSIDE_KILL,
  output logic                        TEST_PULSE_BUSY,
  output logic [7:0]                  SHORT_FLAGS,
  output logic [7:0]                  OPEN_FLAGS
);
  import ipc_pkg::*;

  ipc_chan_if chif ();

  ipc_fault u_fault (
    .CLK   (CLK),
    .RST_N (RST_N),
    .ch    (chif.flt)
  );

  logic            present_r, present_nxt;
  logic [3:0]      cmd_r, cmd_nxt;
  logic [3:0]      kill_r, kill_nxt;
  logic [3:0]      trig_prev_r, trig_prev_nxt;
  ipc_seq_t        seq_r, seq_nxt;
  logic [CNT_W-1:0] tmr_r, tmr_nxt;
  logic [TIME_W-1:0] left_r, left_nxt;
  logic [3:0]      seq_mask_r, seq_mask_nxt;
  logic [3:0]      tp_mask_r, tp_mask_nxt;
  logic [CNT_W-1:0] tp_cnt_r, tp_cnt_nxt;
  logic            cal_armed_r, cal_armed_nxt;
  logic            busy_r, busy_nxt;
  logic [7:0]      sflag_r, oflag_r;
  logic [3:0]      level, rise, fall, edge_hit, mode_cmd;
  logic            run;

  assign run = present_r;

  always_comb begin
    present_nxt = MODULE_ENABLE & SLOT_OCCUPIED & EXT_POWERED;
    level = DIG_IN ^ DIG_INVERT;
    trig_prev_nxt = level;
    rise = level & ~trig_prev_r;
    fall = ~level & trig_prev_r;
    edge_hit = TRIG_FALLING ? fall : rise;
  end

  // sequence engine shared by calibration, triggered and angle modes
  always_comb begin
    seq_nxt = seq_r;
    tmr_nxt = tmr_r;
    left_nxt = left_r;
    seq_mask_nxt = seq_mask_r;
    cal_armed_nxt = cal_armed_r;
    case (seq_r)
      IPC_S_IDLE: begin
        if (run && COMMAND_MODE_SELECT == IPC_CAL && PULSE_COUNT != 16'h0000
            && ipc_popcount(CHAN_ENABLE) == 3'h1 && cal_armed_r) begin
          seq_nxt = IPC_S_ON;
          cal_armed_nxt = 1'b0;
          seq_mask_nxt = CHAN_ENABLE;
          tmr_nxt = CNT_RST;
          left_nxt = PULSE_COUNT;
        end else if (run && COMMAND_MODE_SELECT == IPC_TRIG
                     && |(edge_hit & CHAN_ENABLE)) begin
          seq_nxt = IPC_S_ON;
          seq_mask_nxt = edge_hit & CHAN_ENABLE;
          tmr_nxt = CNT_RST;
          left_nxt = PULSE_COUNT;
        end else if (run && COMMAND_MODE_SELECT == IPC_ANGLE
                     && ANGLE_EVENT) begin
          seq_nxt = IPC_S_ON;
          seq_mask_nxt = CHAN_ENABLE;
          tmr_nxt = CNT_RST;
          left_nxt = 16'h0001;
        end
      end
      IPC_S_ON: begin
        tmr_nxt = tmr_r + 32'h0000_0001;
        if (tmr_r + 32'h0000_0001 >= PULSE_ON_CYC) begin
          left_nxt = left_r - 16'h0001;
          seq_nxt = (left_r <= 16'h0001) ? IPC_S_IDLE : IPC_S_OFF;
        end
      end
      IPC_S_OFF: begin
        tmr_nxt = tmr_r + 32'h0000_0001;
        if (COMMAND_MODE_SELECT == IPC_ANGLE) begin
          if (ANGLE_EVENT) begin
            seq_nxt = IPC_S_ON;
            tmr_nxt = CNT_RST;
          end
        end else if (tmr_r + 32'h0000_0001 >= PULSE_PERIOD_CYC) begin
          seq_nxt = IPC_S_ON;
          tmr_nxt = CNT_RST;
        end
      end
      default: seq_nxt = IPC_S_IDLE;
    endcase
    if (!run) begin
      seq_nxt = IPC_S_IDLE;
    end
    // one calibration run per entry into the mode, else it would repeat
    if (!run || COMMAND_MODE_SELECT != IPC_CAL) begin
      cal_armed_nxt = 1'b1;
    end
  end

  // test pulse: channel picked from selector, duration in milliseconds
  always_comb begin
    tp_mask_nxt = tp_mask_r;
    tp_cnt_nxt = tp_cnt_r;
    if (|tp_mask_r) begin
      tp_cnt_nxt = tp_cnt_r - 32'h0000_0001;
      if (tp_cnt_r <= 32'h0000_0001) begin
        tp_mask_nxt = CH_RST;
      end
    end else if (run && TEST_PULSE_REQUEST && TEST_PULSE_DURATION != 16'h0000
                 && TEST_PULSE_CHANNEL != IPC_TP_OFF) begin
      tp_mask_nxt = 4'h1 << (TEST_PULSE_CHANNEL - 3'h1);
      tp_cnt_nxt = CNT_W'(TEST_PULSE_DURATION) * CNT_W'(CYC_PER_MS);
    end
    busy_nxt = |tp_mask_nxt;
  end

  always_comb begin
    mode_cmd = CH_RST;
    case (COMMAND_MODE_SELECT)
      IPC_DIRECT: mode_cmd = level & CHAN_ENABLE;
      IPC_CAL, IPC_TRIG, IPC_ANGLE:
        mode_cmd = (seq_r == IPC_S_ON) ? seq_mask_r : CH_RST;
      default: mode_cmd = CH_RST;
    endcase
    // open faults never gate a channel, only shorts do
    cmd_nxt = run ? ((mode_cmd | tp_mask_r) & ~sflag_r[3:0]) : CH_RST;
    kill_nxt = sflag_r[7:4];
  end

  assign chif.cmd         = cmd_r;
  assign chif.cmd_end     = cmd_r & ~cmd_nxt;
  assign chif.short_det   = SHORT_DETECT;
  assign chif.low_reached = LOW_SETPOINT_REACHED;
  assign chif.ls_end      = LOWSIDE_CMD_END;
  assign chif.clear       = {8{CRITICAL_FAULT_CLEAR}};
  assign chif.override    = OPEN_FAULT_OVERRIDE;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      present_r   <= 1'b0;
      cmd_r       <= CH_RST;
      kill_r      <= CH_RST;
      trig_prev_r <= CH_RST;
      seq_r       <= IPC_S_IDLE;
      tmr_r       <= CNT_RST;
      left_r      <= 16'h0000;
      seq_mask_r  <= CH_RST;
      tp_mask_r   <= CH_RST;
      tp_cnt_r    <= CNT_RST;
      sflag_r     <= 8'h00;
      oflag_r     <= 8'h00;
      cal_armed_r <= 1'b1;
      busy_r      <= 1'b0;
    end else begin
      present_r   <= present_nxt;
      cmd_r       <= cmd_nxt;
      kill_r      <= kill_nxt;
      trig_prev_r <= trig_prev_nxt;
      seq_r       <= seq_nxt;
      tmr_r       <= tmr_nxt;
      left_r      <= left_nxt;
      seq_mask_r  <= seq_mask_nxt;
      tp_mask_r   <= tp_mask_nxt;
      tp_cnt_r    <= tp_cnt_nxt;
      sflag_r     <= chif.short_flag;
      oflag_r     <= chif.open_flag;
      cal_armed_r <= cal_armed_nxt;
      busy_r      <= busy_nxt;
    end
  end

  assign MODULE_PRESENT_FLAG = present_r;
  assign INJ_CMD             = cmd_r;
  assign LOWSIDE_KILL        = kill_r;
  assign TEST_PULSE_BUSY     = busy_r;
  assign SHORT_FLAGS         = sflag_r;
  assign OPEN_FLAGS          = oflag_r;

  property p_present;
    @(posedge CLK) disable iff (!RST_N)
      !MODULE_ENABLE |=> !MODULE_PRESENT_FLAG;
  endproperty
  a_present: assert property (p_present) else $error("present w/o enable");

  property p_direct;
    @(posedge CLK) disable iff (!RST_N)
      run && COMMAND_MODE_SELECT == IPC_DIRECT && tp_mask_r == 4'h0
      && sflag_r[0] == 1'b0 && CHAN_ENABLE[0]
      |=> INJ_CMD[0] == $past(DIG_IN[0] ^ DIG_INVERT[0]);
  endproperty
  a_direct: assert property (p_direct) else $error("direct mismatch");

  property p_cal_block;
    @(posedge CLK) disable iff (!RST_N)
      seq_r == IPC_S_IDLE && COMMAND_MODE_SELECT == IPC_CAL
      && ipc_popcount(CHAN_ENABLE) > 3'h1 |=> seq_r == IPC_S_IDLE;
  endproperty
  a_cal_block: assert property (p_cal_block) else $error("cal multi");

  property p_short_off;
    @(posedge CLK) disable iff (!RST_N)
      sflag_r[2] |=> !INJ_CMD[2];
  endproperty
  a_short_off: assert property (p_short_off) else $error("short ch on");

  property p_tp_off;
    @(posedge CLK) disable iff (!RST_N)
      tp_mask_r == 4'h0 && TEST_PULSE_CHANNEL == IPC_TP_OFF |=> tp_mask_r == 4'h0;
  endproperty
  a_tp_off: assert property (p_tp_off) else $error("tp disabled fired");

  property p_cal_once;
    @(posedge CLK) disable iff (!RST_N)
      seq_r == IPC_S_IDLE && !cal_armed_r && COMMAND_MODE_SELECT == IPC_CAL
      |=> seq_r == IPC_S_IDLE;
  endproperty
  a_cal_once: assert property (p_cal_once) else $error("cal rerun");

  property p_ls_kill;
    @(posedge CLK) disable iff (!RST_N)
      run |=> LOWSIDE_KILL == $past(SHORT_FLAGS[7:4]);
  endproperty
  a_ls_kill: assert property (p_ls_kill) else $error("lowside kill");

  property p_trig_start;
    @(posedge CLK) disable iff (!RST_N)
      run && COMMAND_MODE_SELECT == IPC_TRIG && seq_r == IPC_S_IDLE
      && CHAN_ENABLE[0] && !TRIG_FALLING && (DIG_IN[0] ^ DIG_INVERT[0])
      && !$past(DIG_IN[0] ^ DIG_INVERT[0]) |=> seq_r == IPC_S_ON;
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("no trig");

  property p_angle_start;
    @(posedge CLK) disable iff (!RST_N)
      run && COMMAND_MODE_SELECT == IPC_ANGLE && seq_r == IPC_S_IDLE
      && ANGLE_EVENT |=> seq_r == IPC_S_ON;
  endproperty
  a_angle_start: assert property (p_angle_start) else $error("no angle");

  property p_open_run;
    @(posedge CLK) disable iff (!RST_N)
      run && COMMAND_MODE_SELECT == IPC_DIRECT && OPEN_FLAGS[1]
      && !sflag_r[1] && CHAN_ENABLE[1] && (DIG_IN[1] ^ DIG_INVERT[1])
      |=> INJ_CMD[1];
  endproperty
  a_open_run: assert property (p_open_run) else $error("open gated");

  property p_tp_one;
    @(posedge CLK) disable iff (!RST_N)
      TEST_PULSE_BUSY |-> $onehot(tp_mask_r);
  endproperty
  a_tp_one: assert property (p_tp_one) else $error("tp not one ch");

  c_direct: cover property (@(posedge CLK) INJ_CMD[0]);
  c_tp:     cover property (@(posedge CLK) TEST_PULSE_BUSY);
  c_seq:    cover property (@(posedge CLK) seq_r == IPC_S_OFF);
endmodule

/* File: bench/ipc_sense_model.sv */
// current sense model of the four injector loads; the four lowside sense bits stay low
// assumes commands are registered on CLK; open_mask marks broken loads
`timescale 1ns/10ps
module ipc_sense_model (
  // clock
  input  wire logic       CLK,
  // load command and wiring state
  input  wire logic [3:0] inj_cmd,
  input  wire logic [7:0] open_mask,
  // sense result
  output logic      [7:0] low_reached
);
  logic [3:0] cmd_d;
  // current takes a cycle to build, so the first cycle never reaches it
  always_ff @(posedge CLK) begin
    cmd_d <= inj_cmd;
  end
  // an open load never reaches the lower setpoint; lowside sense unused
  assign low_reached = {4'h0, cmd_d & inj_cmd} & ~open_mask;
endmodule

/* File: bench/ipc_top_bench.sv */
// self-checking bench of the injector command and fault block
// assumes 100 MHz CLK; inputs move on the falling edge
`timescale 1ns/10ps
module ipc_top_bench;
  import ipc_pkg::*;
  logic             clk, rst_n, en, slot, pwr, trig_f, ang, tp_req, clr;
  logic             ovr, present, busy;
  ipc_mode_t        mode;
  ipc_tpsel_t       tp_ch;
  logic [3:0]       ch_en, din, dinv, ls_end, cmd, kill, prev;
  logic [CNT_W-1:0] on_cyc, per_cyc;
  logic [TIME_W-1:0] cnt, tp_dur;
  logic [7:0]       sdet, reached, open_mask, sflags, oflags;
  int               fail_count, checked, edges;

  ipc_top i_ipc_top (.CLK(clk), .RST_N(rst_n), .MODULE_ENABLE(en),
    .SLOT_OCCUPIED(slot), .EXT_POWERED(pwr), .COMMAND_MODE_SELECT(mode),
    .CHAN_ENABLE(ch_en), .DIG_IN(din), .DIG_INVERT(dinv),
    .TRIG_FALLING(trig_f), .ANGLE_EVENT(ang), .PULSE_ON_CYC(on_cyc),
    .PULSE_PERIOD_CYC(per_cyc), .PULSE_COUNT(cnt),
    .TEST_PULSE_REQUEST(tp_req), .TEST_PULSE_CHANNEL(tp_ch),
    .TEST_PULSE_DURATION(tp_dur), .CRITICAL_FAULT_CLEAR(clr),
    .OPEN_FAULT_OVERRIDE(ovr), .SHORT_DETECT(sdet),
    .LOW_SETPOINT_REACHED(reached), .LOWSIDE_CMD_END(ls_end),
    .MODULE_PRESENT_FLAG(present), .INJ_CMD(cmd), .LOWSIDE_KILL(kill),
    .TEST_PULSE_BUSY(busy), .SHORT_FLAGS(sflags), .OPEN_FLAGS(oflags));

  ipc_sense_model i_ipc_sense_model (.CLK(clk), .inj_cmd(cmd),
    .open_mask(open_mask), .low_reached(reached));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // counts command pulses of any channel, seen where outputs are settled
  always @(negedge clk) begin
    if (cmd !== 4'h0 && prev === 4'h0) edges++;
    prev <= cmd;
  end

  function automatic logic [7:0] present_exp(input int i);
    return {7'h0, i == 7};
  endfunction

  function automatic logic [7:0] direct_exp(input logic [3:0] d, v);
    return {4'h0, d ^ v};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic pulse_req();
    tp_req = 1'b1;
    cyc(1);
    tp_req = 1'b0;
    cyc(3);
  endtask

  task automatic give_verdict();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end

  initial begin
    {rst_n, en, slot, pwr, trig_f, ang, tp_req, clr, ovr} = 9'h000;
    mode = IPC_DIRECT;
    tp_ch = IPC_TP_OFF;
    {ch_en, din, dinv, ls_end} = {4'hF, 4'h0, 4'h0, 4'h0};
    {on_cyc, per_cyc, cnt, tp_dur} = {32'h3, 32'h8, 16'h5, 16'h1};
    {sdet, open_mask, prev} = {8'h00, 8'h00, 4'h0};
    edges = 0;
    void'($urandom(79));
    cyc(3);
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      {en, slot, pwr} = i[2:0];
      cyc(2);
      chk({7'h0, present}, present_exp(i));
    end
    $display("test present done");
    repeat (20) begin
      din = 4'($urandom);
      dinv = 4'($urandom);
      cyc(2);
      chk({4'h0, cmd}, direct_exp(din, dinv));
      chk({4'h0, kill}, 8'h00);
    end
    $display("test direct done");
    {dinv, din, open_mask} = {4'h0, 4'hF, 8'h02};
    cyc(5);
    din = 4'h0;
    cyc(3);
    chk(oflags, 8'h02);
    din = 4'hF;
    cyc(3);
    chk({4'h0, cmd}, 8'h0F);
    // the load mends mid pulse, so the flag must drop at this pulse end
    open_mask = 8'h00;
    cyc(3);
    din = 4'h0;
    cyc(3);
    chk(oflags, 8'h00);
    {ovr, open_mask, din} = {1'b1, 8'h02, 4'hF};
    cyc(5);
    din = 4'h0;
    cyc(3);
    chk(oflags, 8'h00);
    {ovr, open_mask, ls_end} = {1'b0, 8'h00, 4'h1};
    cyc(1);
    ls_end = 4'h0;
    cyc(3);
    chk(oflags, 8'h10);
    $display("test open done");
    {din, sdet} = {4'hF, 8'h14};
    cyc(1);
    sdet = 8'h00;
    cyc(3);
    chk(sflags, 8'h14);
    chk({4'h0, cmd}, 8'h0B);
    cyc(20);
    chk({kill, cmd}, 8'h1B);
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(3);
    chk({sflags[7:4], cmd}, 8'h0F);
    $display("test short done");
    {din, ch_en} = {4'h0, 4'h1};
    cyc(2);
    mode = IPC_CAL;
    edges = 0;
    cyc(200);
    chk(8'(edges), 8'(cnt));
    mode = IPC_DIRECT;
    ch_en = 4'h3;
    cyc(2);
    mode = IPC_CAL;
    edges = 0;
    cyc(200);
    chk(8'(edges), 8'h00);
    $display("test cal done");
    for (int f = 0; f < 2; f++) begin
      mode = IPC_DIRECT;
      {ch_en, trig_f, din} = {4'hF, f[0], {4{f[0]}}};
      cyc(2);
      mode = IPC_TRIG;
      cyc(2);
      edges = 0;
      din = ~din;
      cyc(200);
      chk(8'(edges), 8'(cnt));
    end
    mode = IPC_ANGLE;
    din = 4'h0;
    edges = 0;
    repeat (3) begin
      ang = 1'b1;
      cyc(1);
      ang = 1'b0;
      cyc(20);
    end
    chk(8'(edges), 8'h03);
    $display("test sequence done");
    mode = IPC_DIRECT;
    cyc(2);
    pulse_req();
    chk({3'h0, busy, cmd}, 8'h00);
    tp_ch = IPC_TP_CH3;
    pulse_req();
    chk({3'h0, busy, cmd}, 8'h14);
    cyc(1000);
    chk({3'h0, busy, cmd}, 8'h14);
    rst_n = 1'b0;
    cyc(1);
    chk({3'h0, busy, cmd}, 8'h00);
    rst_n = 1'b1;
    cyc(2);
    chk({3'h0, busy, cmd}, 8'h00);
    $display("test pulse done");
    give_verdict();
  end
endmodule
